// ---- rtl/spar_map.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef SPAR_MAP_SVH
`define SPAR_MAP_SVH
`define SPAR_OFS_CTRL    8'h98
`define SPAR_OFS_BUF     8'h99
`define SPAR_OFS_ADDR    8'hA9
`define SPAR_OFS_MASK    8'hB9
`define SPAR_OFS_PWR     8'h87
`define SPAR_B_SM0FE     7
`define SPAR_B_SM1       6
`define SPAR_B_AME       5
`define SPAR_B_REN       4
`define SPAR_B_TB8       3
`define SPAR_B_RB8       2
`define SPAR_B_TI        1
`define SPAR_B_RI        0
`define SPAR_B_DBL       7
`define SPAR_B_FSEL      6
`define SPAR_RST_CTRL    8'h00
`define SPAR_RST_ADDR    8'h00
`define SPAR_RST_MASK    8'h00
`define SPAR_RST_PWR     8'h00
`define SPAR_DIV_SHIFT   4'hB
`define SPAR_DIV_FIXED   6'h03
`define SPAR_DIV_FIXED_DBL 6'h01
`define SPAR_OVS_LAST    4'hF
`define SPAR_OVS_MID     4'h7
`endif

// ---- rtl/spar_pkg.sv ----
// types shared by the serial port with address recognition
package spar_pkg;
  typedef enum logic [3:0] {
    SPAR_TX_IDLE = 4'b0001,
    SPAR_TX_RUN  = 4'b0010,
    SPAR_TX_SHFT = 4'b0100,
    SPAR_TX_XX   = 4'b1000
  } spar_tx_e;
  typedef enum logic [3:0] {
    SPAR_RX_IDLE  = 4'b0001,
    SPAR_RX_START = 4'b0010,
    SPAR_RX_DATA  = 4'b0100,
    SPAR_RX_SHFT  = 4'b1000
  } spar_rx_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } spar_bus_s;
  typedef struct packed {
    logic [7:0] ctrl;
    logic       fe;
    logic [7:0] pwr;
    logic [7:0] slave_addr;
    logic [7:0] smask;
    logic [7:0] rxbuf;
    logic [7:0] rdata;
    logic [1:0] rx_sync;
    logic       rx_prev;
    logic [3:0] div12;
    logic       pre_tick;
    logic [5:0] fdiv;
    spar_tx_e   tx_st;
    logic [3:0] tx_ovs;
    logic [3:0] tx_cnt;
    logic [9:0] tx_sh;
    logic       txd;
    logic       sclk;
    spar_rx_e   rx_st;
    logic [3:0] rx_ovs;
    logic [3:0] rx_cnt;
    logic [8:0] rx_sh;
  } spar_state_s;
endpackage

// ---- rtl/spar_uart.sv ----
// serial port with four modes, framing check and address recognition
`timescale 1ns/1ps
`include "spar_map.svh"
module spar_uart
  import spar_pkg::*;
(
  input  wire logic       sys_clk,      // system clock, 125 MHz
  input  wire logic       reset_n,      // async reset, active low
  input  wire logic       clk_en,       // freezes all state when low
  input  wire logic [7:0] reg_addr,     // register address
  input  wire logic [7:0] reg_wdata,    // write data
  input  wire logic       reg_wr,       // write strobe
  input  wire logic       reg_rd,       // read strobe
  output logic      [7:0] reg_rdata,    // read data, cycle after strobe
  input  wire logic       t1_overflow,  // timer 1 overflow pulse
  input  wire logic       rxd_in,       // serial_in_pin level
  output logic            rxd_out,      // serial_in_pin drive value
  output logic            rxd_oe,       // serial_in_pin drive enable
  output logic            txd_out       // serial_out_pin
);
  spar_state_s r, n;
  spar_bus_s   bus;
  logic [1:0] mode;
  logic       async_m, nine_m, ovs_tick, rxs, wr_buf, rd_hit;
  logic [7:0] given_cmp, bcast, rxbyte;
  logic       addr_ok, stop_ok, ninth, accept;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // mode decode; the mode bit is kept even while bit 7 shows the flag
  // mode encoding
  assign mode    = {r.ctrl[`SPAR_B_SM0FE], r.ctrl[`SPAR_B_SM1]};
  assign async_m = (mode != 2'b00);
  assign nine_m  = mode[1];
  assign rxs     = r.rx_sync[1];
  assign wr_buf  = bus.wr && (bus.addr == `SPAR_OFS_BUF);
  assign rd_hit  = bus.rd;

  // oversample tick: timer overflow or fixed divider, doubler halves it
  // baud source
  always_comb begin
    if (mode == 2'b10) begin
      // 16 ticks per bit: clock over 32 with doubler, over 64 without
      ovs_tick = r.pwr[`SPAR_B_DBL] ? (r.fdiv == `SPAR_DIV_FIXED_DBL)
                                    : (r.fdiv == `SPAR_DIV_FIXED);
    end else begin
      ovs_tick = t1_overflow && (r.pwr[`SPAR_B_DBL] || r.pre_tick);
    end
  end

  // address match on the received byte
  // masked given compare
  assign given_cmp = (rxbyte ^ r.slave_addr) & r.smask;
  assign bcast     = r.slave_addr | r.smask;
  // zero address and mask leave every bit don't care
  assign addr_ok   = (given_cmp == 8'h00) || (((rxbyte ^ 8'hFF) & bcast) == 8'h00);
  assign rxbyte    = r.rx_sh[7:0];
  assign ninth     = r.rx_sh[8];
  assign stop_ok   = rxs;

  // filter decision, taken mid stop bit
  always_comb begin
    accept = 1'b1;
    if (r.ctrl[`SPAR_B_AME]) begin
      if (nine_m) accept = ninth && addr_ok;
      else accept = stop_ok && addr_ok;
    end
  end

  // next-state logic for the whole block
  always_comb begin
    n = r;
    n.rx_sync = {r.rx_sync[0], rxd_in};
    n.rx_prev = rxs;
    // shift rate is clock over 12
    n.pre_tick = r.pre_tick;
    if (r.div12 == `SPAR_DIV_SHIFT) n.div12 = 4'h0;
    else n.div12 = r.div12 + 4'h1;
    if (t1_overflow) n.pre_tick = ~r.pre_tick;
    n.fdiv = r.fdiv + 6'h01;
    if (ovs_tick) n.fdiv = 6'h00;

    // register writes
    if (bus.wr) begin
      case (bus.addr)
        `SPAR_OFS_CTRL: begin
          if (r.pwr[`SPAR_B_FSEL]) begin
            n.fe = bus.wdata[`SPAR_B_SM0FE];
            n.ctrl[6:0] = bus.wdata[6:0];
          end else begin
            n.ctrl = bus.wdata;
          end
        end
        `SPAR_OFS_PWR:  n.pwr   = bus.wdata;
        `SPAR_OFS_ADDR: n.slave_addr = bus.wdata;
        `SPAR_OFS_MASK: n.smask = bus.wdata;
        default: ;
      endcase
    end

    // read data registered for the next cycle
    // reads of the buffer return the receive register
    n.rdata = 8'h00;
    if (rd_hit) begin
      case (bus.addr)
        `SPAR_OFS_CTRL: n.rdata = r.pwr[`SPAR_B_FSEL] ?
                                  {r.fe, r.ctrl[6:0]} : r.ctrl;
        `SPAR_OFS_BUF:  n.rdata = r.rxbuf;
        `SPAR_OFS_PWR:  n.rdata = r.pwr;
        `SPAR_OFS_ADDR: n.rdata = r.slave_addr;
        `SPAR_OFS_MASK: n.rdata = r.smask;
        default:        n.rdata = 8'h00;
      endcase
    end

    // transmitter
    case (r.tx_st)
      SPAR_TX_IDLE: begin
        n.txd  = 1'b1;
        n.sclk = 1'b1;
        if (wr_buf) begin
          n.tx_cnt = 4'h0;
          n.tx_ovs = 4'h0;
          if (async_m) begin
            n.tx_sh = nine_m ? {r.ctrl[`SPAR_B_TB8], bus.wdata, 1'b0}
                             : {1'b1, bus.wdata, 1'b0};
            n.tx_st = SPAR_TX_RUN;
          end else begin
            n.tx_sh = {2'b11, bus.wdata};
            n.tx_st = SPAR_TX_SHFT;
          end
        end
      end
      SPAR_TX_RUN: begin
        n.txd = r.tx_sh[0];
        if (ovs_tick) begin
          n.tx_ovs = r.tx_ovs + 4'h1;
          if (r.tx_ovs == `SPAR_OVS_LAST) begin
            n.tx_sh  = {1'b1, r.tx_sh[9:1]};
            n.tx_cnt = r.tx_cnt + 4'h1;
            // done at start of stop bit
            if (r.tx_cnt == (nine_m ? 4'h9 : 4'h8)) begin
              n.ctrl[`SPAR_B_TI] = 1'b1;
            end
            if (r.tx_cnt == (nine_m ? 4'hA : 4'h9)) n.tx_st = SPAR_TX_IDLE;
          end
        end
      end
      SPAR_TX_SHFT: begin
        // shift clock on the transmit pin, lsb first
        n.txd = r.tx_sh[0];
        if (r.div12 == `SPAR_DIV_SHIFT) begin
          // done at the end of the eighth bit time
          if (r.tx_cnt == 4'h8) begin
            n.ctrl[`SPAR_B_TI] = 1'b1;
            n.tx_st = SPAR_TX_IDLE;
          end else begin
            n.sclk = 1'b0;
          end
        end else if (r.div12 == 4'h5 && !r.sclk) begin
          // rise only after a low phase, so the first bit gets its clock
          n.sclk = 1'b1;
          n.tx_sh = {1'b1, r.tx_sh[9:1]};
          n.tx_cnt = r.tx_cnt + 4'h1;
        end
      end
      default: n.tx_st = SPAR_TX_IDLE;
    endcase

    // receiver
    case (r.rx_st)
      SPAR_RX_IDLE: begin
        n.rx_cnt = 4'h0;
        n.rx_ovs = 4'h0;
        if (r.ctrl[`SPAR_B_REN]) begin
          if (async_m && r.rx_prev && !rxs) n.rx_st = SPAR_RX_START;
          // shift mode start; filter bit not looked at
          if (!async_m && !r.ctrl[`SPAR_B_RI] && r.tx_st == SPAR_TX_IDLE)
            n.rx_st = SPAR_RX_SHFT;
        end
      end
      SPAR_RX_START: begin
        if (ovs_tick) begin
          n.rx_ovs = r.rx_ovs + 4'h1;
          // start must still be low at mid-bit
          if (r.rx_ovs == `SPAR_OVS_MID) begin
            n.rx_ovs = 4'h0;
            n.rx_st  = rxs ? SPAR_RX_IDLE : SPAR_RX_DATA;
          end
        end
      end
      SPAR_RX_DATA: begin
        if (ovs_tick) begin
          n.rx_ovs = r.rx_ovs + 4'h1;
          if (r.rx_ovs == `SPAR_OVS_LAST) begin
            n.rx_cnt = r.rx_cnt + 4'h1;
            // stop bit reached mid-bit
            if (r.rx_cnt == (nine_m ? 4'h9 : 4'h8)) begin
              n.rx_st = SPAR_RX_IDLE;
              if (!rxs) n.fe = 1'b1;
              if (accept) begin
                n.ctrl[`SPAR_B_RI] = 1'b1;
                n.rxbuf = rxbyte;
                // ninth bit, or stop bit in 8-bit mode with the filter off
                if (nine_m) n.ctrl[`SPAR_B_RB8] = ninth;
                else if (!r.ctrl[`SPAR_B_AME]) n.ctrl[`SPAR_B_RB8] = rxs;
              end
            end else if (nine_m || r.rx_cnt < 4'h8) begin
              n.rx_sh = nine_m ? {rxs, r.rx_sh[8:1]}
                               : {1'b0, rxs, r.rx_sh[7:1]};
            end
          end
        end
        if (!r.ctrl[`SPAR_B_REN]) n.rx_st = SPAR_RX_IDLE;
      end
      SPAR_RX_SHFT: begin
        n.sclk = (r.div12 >= 4'h6);
        if (r.div12 == 4'h5 && !r.sclk) begin
          n.rx_sh  = {1'b0, rxs, r.rx_sh[7:1]};
          n.rx_cnt = r.rx_cnt + 4'h1;
          if (r.rx_cnt == 4'h7) begin
            n.ctrl[`SPAR_B_RI] = 1'b1;
            n.rxbuf = {rxs, r.rx_sh[7:1]};
            n.rx_st = SPAR_RX_IDLE;
          end
        end
        if (!r.ctrl[`SPAR_B_REN]) n.rx_st = SPAR_RX_IDLE;
      end
      default: n.rx_st = SPAR_RX_IDLE;
    endcase
    if (r.rx_st == SPAR_RX_SHFT && n.rx_st == SPAR_RX_IDLE) n.sclk = 1'b1;
  end

  // single register stage for all state
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '{ctrl: `SPAR_RST_CTRL, fe: 1'b0, pwr: `SPAR_RST_PWR,
             slave_addr: `SPAR_RST_ADDR, smask: `SPAR_RST_MASK,
             rxbuf: 8'h00, rdata: 8'h00, rx_sync: 2'b11, rx_prev: 1'b1,
             div12: 4'h0, pre_tick: 1'b0, fdiv: 6'h00,
             tx_st: SPAR_TX_IDLE, tx_ovs: 4'h0, tx_cnt: 4'h0,
             tx_sh: 10'h3FF, txd: 1'b1, sclk: 1'b1,
             rx_st: SPAR_RX_IDLE, rx_ovs: 4'h0, rx_cnt: 4'h0,
             rx_sh: 9'h000};
    end else if (clk_en) begin
      r <= n;
    end
  end

  // outputs; in shift mode the transmit pin carries the clock
  assign reg_rdata = r.rdata;
  assign txd_out   = (r.tx_st == SPAR_TX_SHFT || r.rx_st == SPAR_RX_SHFT)
                     ? r.sclk : r.txd;
  assign rxd_out   = r.txd;
  assign rxd_oe    = (r.tx_st == SPAR_TX_SHFT);

  // framing flag never cleared by the receiver itself
  sticky_fe_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (r.fe && clk_en && !(bus.wr && bus.addr == `SPAR_OFS_CTRL)) |=> r.fe)
    else $error("framing flag dropped without software");
  // transmit start after buffer write
  tx_start_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && wr_buf && r.tx_st == SPAR_TX_IDLE) |=> r.tx_st != SPAR_TX_IDLE)
    else $error("buffer write did not start transmit");
  // no reception start without enable
  rx_gate_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (r.rx_st == SPAR_RX_IDLE && !r.ctrl[`SPAR_B_REN]) |=>
      r.rx_st == SPAR_RX_IDLE)
    else $error("reception started while disabled");
  // read data one cycle later
  rd_buf_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && bus.rd && bus.addr == `SPAR_OFS_BUF) |=>
      reg_rdata == $past(r.rxbuf))
    else $error("buffer read wrong");
  // address and mask reset
  addr_rst_a: assert property (@(posedge sys_clk)
    $rose(reset_n) |-> (r.slave_addr == 8'h00 && r.smask == 8'h00))
    else $error("address registers not cleared");
  // async idle line high
  tx_idle_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (r.tx_st == SPAR_TX_IDLE && r.rx_st != SPAR_RX_SHFT) |-> txd_out)
    else $error("idle line not high");
  // false start abandoned
  false_st_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && r.rx_st == SPAR_RX_START && ovs_tick &&
     r.rx_ovs == `SPAR_OVS_MID && rxs) |=> r.rx_st == SPAR_RX_IDLE)
    else $error("false start accepted");
  // filtered frame leaves done flag alone
  filt_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && r.rx_st == SPAR_RX_DATA && n.rx_st == SPAR_RX_IDLE &&
     !accept && !r.ctrl[`SPAR_B_RI] && !bus.wr) |=> !r.ctrl[`SPAR_B_RI])
    else $error("filtered frame set done flag");
endmodule

// ---- test/spar_peer.sv ----
// peer serial node model: drives frames and decodes the device's frames
`timescale 1ns/1ps
module spar_peer #(
  parameter int BIT = 16  // clocks per bit on the line toward the device
) (
  input  wire logic sys_clk,  // system clock
  input  wire logic line_in,  // device transmit line
  input  wire logic data_in,  // receive pin as seen on the wire
  output logic      line_out  // line toward the device receive pin
);
  // idle line rests high, like a pulled-up port pin
  initial line_out = 1'b1;

  // hold one level for a whole bit time
  task automatic drive_bit(input logic b);
    line_out <= b;
    repeat (BIT) @(posedge sys_clk);
  endtask

  // frame layout
  // start low, data lsb first, optional ninth bit, then stop level
  task automatic send(input logic [7:0] d, input logic n, input logic h,
                      input logic s);
    drive_bit(1'b0);
    for (int i = 0; i < 8; i++) drive_bit(d[i]);
    if (h) drive_bit(n);
    drive_bit(s);
    drive_bit(1'b1);
  endtask

  // shift-mode capture: one bit per rising shift clock
  task automatic shift_in(output logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(posedge line_in);
      d[i] = data_in;
    end
  endtask

  // shift-mode source: next bit right after each rising clock
  task automatic shift_out(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      line_out <= d[i];
      @(posedge line_in);
    end
    line_out <= 1'b1;
  endtask

  // frame decode
  // sample each bit at its centre, timed from the falling start edge
  task automatic recv(input int bt, input logic h, output logic [10:0] f);
    f = '0;
    @(negedge line_in);
    repeat (bt / 2) @(posedge sys_clk);
    f[0] = line_in;
    for (int i = 1; i < (h ? 11 : 10); i++) begin
      repeat (bt) @(posedge sys_clk);
      f[i] = line_in;
    end
  endtask
endmodule

// ---- test/test_serial_port_addr_recognition.sv ----
// self-checking bench for the serial port with address recognition
`timescale 1ns/1ps
`include "spar_map.svh"
module test_serial_port_addr_recognition;
  localparam int BIT = 16;  // doubler on, timer overflow every clock
  logic        sys_clk     = 1'b0;
  logic        reset_n     = 1'b0;
  logic        clk_en      = 1'b1;
  logic        t1_overflow = 1'b1;
  logic [7:0]  reg_addr    = 8'h00;
  logic [7:0]  reg_wdata   = 8'h00;
  logic        reg_wr      = 1'b0;
  logic        reg_rd      = 1'b0;
  logic [7:0]  reg_rdata;
  logic        rxd_out, rxd_oe, txd_out, peer_line;
  wire  logic  rxd_line;
  int          error_cnt   = 0;
  int          n_checks    = 0;

  // shared receive pin: the device wins only while it drives it
  assign rxd_line = rxd_oe ? rxd_out : peer_line;

  always #4 sys_clk = ~sys_clk;

  spar_uart i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .t1_overflow(t1_overflow),
    .rxd_in(rxd_line), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .txd_out(txd_out));

  spar_peer #(.BIT(BIT)) i_peer (.sys_clk(sys_clk), .line_in(txd_out),
    .data_in(rxd_line), .line_out(peer_line));

  // one-cycle write strobe beside address and data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic t_reset;
    logic [7:0] v;
    rd(`SPAR_OFS_CTRL, v);
    chk(v, `SPAR_RST_CTRL);
    rd(`SPAR_OFS_ADDR, v);
    chk(v, 8'h00);
    rd(`SPAR_OFS_MASK, v);
    chk(v, 8'h00);
    rd(8'h9A, v);
    chk(v, 8'h00);
    chk(txd_out, 1'b1);
    $display("reset test done");
  endtask

  // start a transmission and let the peer decode it; the trailing wait
  // keeps the next buffer write clear of the running stop bit
  task automatic tx_frame(input int bt, input logic h, input logic [7:0] d,
                          output logic [10:0] f);
    fork
      i_peer.recv(bt, h, f);
      wr(`SPAR_OFS_BUF, d);
    join
    repeat (bt) @(posedge sys_clk);
  endtask

  task automatic t_tx;
    logic [7:0]  v;
    logic [10:0] f;
    wr(`SPAR_OFS_PWR, 8'h80);
    wr(`SPAR_OFS_CTRL, 8'h50);
    tx_frame(BIT, 1'b0, 8'hA5, f);
    chk(f[9:0], {1'b1, 8'hA5, 1'b0});
    rd(`SPAR_OFS_CTRL, v);
    chk(v, 8'h52);
    for (int t = 0; t < 2; t++) begin
      wr(`SPAR_OFS_CTRL, {4'hC, t[0], 3'h0});
      tx_frame(BIT, 1'b1, 8'h5A, f);
      chk(f, {1'b1, t[0], 8'h5A, 1'b0});
    end
    // fixed-rate 9-bit mode with doubler: 32 clocks per bit
    wr(`SPAR_OFS_CTRL, 8'h88);
    tx_frame(32, 1'b1, 8'hC3, f);
    chk(f, {1'b1, 1'b1, 8'hC3, 1'b0});
    $display("transmit test done");
  endtask

  // shift-register mode: send on the receive pin, then receive
  task automatic t_shift;
    logic [7:0] v;
    wr(`SPAR_OFS_CTRL, 8'h00);
    fork
      i_peer.shift_in(v);
      wr(`SPAR_OFS_BUF, 8'h96);
    join
    chk(v, 8'h96);
    chk(rxd_oe, 1'b1);
    repeat (12) @(posedge sys_clk);
    chk(rxd_oe, 1'b0);
    rd(`SPAR_OFS_CTRL, v);
    chk(v, 8'h02);
    fork
      i_peer.shift_out(8'h5B);
      wr(`SPAR_OFS_CTRL, 8'h10);
    join
    repeat (12) @(posedge sys_clk);
    rd(`SPAR_OFS_CTRL, v);
    chk(v, 8'h11);
    rd(`SPAR_OFS_BUF, v);
    chk(v, 8'h5B);
    $display("shift mode test done");
  endtask

  task automatic t_rx;
    logic [7:0] v;
    wr(`SPAR_OFS_CTRL, 8'h52);
    i_peer.send(8'h3C, 1'b0, 1'b0, 1'b1);
    rd(`SPAR_OFS_CTRL, v);
    chk(v, 8'h57);
    rd(`SPAR_OFS_BUF, v);
    chk(v, 8'h3C);
    // bad stop bit, then a good frame must leave the flag standing
    wr(`SPAR_OFS_PWR, 8'hC0);
    i_peer.send(8'h0F, 1'b0, 1'b0, 1'b0);
    rd(`SPAR_OFS_CTRL, v);
    chk(v[7], 1'b1);
    wr(`SPAR_OFS_CTRL, 8'hD0);
    i_peer.send(8'h0F, 1'b0, 1'b0, 1'b1);
    rd(`SPAR_OFS_CTRL, v);
    chk(v[7], 1'b1);
    wr(`SPAR_OFS_CTRL, 8'h50);
    rd(`SPAR_OFS_CTRL, v);
    chk(v[7], 1'b0);
    wr(`SPAR_OFS_PWR, 8'h80);
    rd(`SPAR_OFS_CTRL, v);
    chk(v[7:6], 2'b01);
    $display("receive test done");
  endtask

  // one received frame under a given control value, then the done flag
  task automatic filt(input logic [7:0] c, input logic [7:0] d,
                      input logic n, input logic h, input logic s,
                      input logic e);
    logic [7:0] v;
    wr(`SPAR_OFS_CTRL, c);
    i_peer.send(d, n, h, s);
    rd(`SPAR_OFS_CTRL, v);
    chk(v[0], e);
    if (e === 1'b1 && h === 1'b1)
      chk(v[2], n);
  endtask

  task automatic t_filt;
    wr(`SPAR_OFS_ADDR, 8'hC0);
    wr(`SPAR_OFS_MASK, 8'hFD);
    filt(8'hF0, 8'hC2, 1'b0, 1'b1, 1'b1, 1'b0);
    filt(8'hF0, 8'hC2, 1'b1, 1'b1, 1'b1, 1'b1);
    filt(8'hF0, 8'hFF, 1'b1, 1'b1, 1'b1, 1'b1);
    filt(8'hF0, 8'h40, 1'b1, 1'b1, 1'b1, 1'b0);
    filt(8'h70, 8'hC0, 1'b0, 1'b0, 1'b0, 1'b0);
    filt(8'h70, 8'h41, 1'b0, 1'b0, 1'b1, 1'b0);
    filt(8'h70, 8'hC0, 1'b0, 1'b0, 1'b1, 1'b1);
    filt(8'h40, 8'hC0, 1'b0, 1'b0, 1'b1, 1'b0);
    $display("address filter test done");
  endtask

  // reset, then the scenarios in turn
  initial begin
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset;
    t_tx;
    t_shift;
    t_rx;
    t_filt;
    summarize;
  end

  // watchdog: the scenarios need well under half this span
  initial begin
    repeat (40000) @(posedge sys_clk);
    error_cnt++;
    $display("watchdog expired");
    summarize;
  end
endmodule
